// file: src/oper_addr_params.svh
/*
  Constants for the operand address generator: window bounds, implied
  register codes, register pair codes and the bank base shift.
  Assumes inclusion from the modules by bare name.
*/
`ifndef OPER_ADDR_PARAMS_SVH
`define OPER_ADDR_PARAMS_SVH

`define SADDR_LO 16'hFE20
`define SADDR_HI 16'hFF1F
`define SADDR_SFR_SPLIT 8'h20
`define SFR_BASE 16'hFF00
`define SFR_HOLE_LO 16'hFFD0
`define SFR_HOLE_HI 16'hFFDF
`define STACK_RAM_LO_DEF 16'hFB00
`define STACK_RAM_HI_DEF 16'hFEFF
`define REG_X 3'h0
`define REG_A 3'h1
`define REG_C 3'h2
`define REG_B 3'h3
`define PAIR_AX 2'h0
`define PAIR_DE 2'h2
`define PAIR_HL 2'h3
`define BANK_BASE_SHIFT 3

`endif

// file: src/oper_addr_pkg.sv
/*
  Types shared by the operand address generator and its file lookup.
  Assumes the params header is on the include path.
*/
package oper_addr_pkg;
  typedef enum logic [3:0] {
    mode_implied = 4'h0,
    mode_register = 4'h1,
    mode_direct = 4'h3,
    mode_short_direct = 4'h2,
    mode_sfr = 4'h6,
    mode_reg_indirect = 4'h7,
    mode_based = 4'h5,
    mode_based_indexed = 4'h4,
    mode_stack = 4'hC
  } addr_mode_e;

  typedef enum logic [2:0] {
    imp_none = 3'h0,
    imp_multiply = 3'h1,
    imp_divide = 3'h2,
    imp_adjust_add = 3'h3,
    imp_adjust_sub = 3'h4,
    imp_rotate_left = 3'h5,
    imp_rotate_right = 3'h6
  } implied_op_e;
endpackage

// file: src/gpr_lookup_if.sv
/*
  Carrier between the address generator and the register file lookup.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface gpr_lookup_if;
  logic [1:0] bank;
  logic [2:0] reg_code;
  logic [1:0] pair_code;
  logic [7:0] reg_val;
  logic [15:0] pair_val;
  logic [15:0] hl_val;
  logic [7:0] b_val;
  logic [7:0] c_val;
  modport requester (output bank, output reg_code, output pair_code,
    input reg_val, input pair_val, input hl_val, input b_val, input c_val);
  modport provider (input bank, input reg_code, input pair_code,
    output reg_val, output pair_val, output hl_val, output b_val, output c_val);
endinterface
`default_nettype wire

// file: src/gpr_lookup.sv
/*
  Reads the flat general register file: 4 banks of 8 bytes.
  Assumes the file arrives as a flat vector, bank 0 at the low end.
*/
`timescale 1ns/1ps
`default_nettype none
module gpr_lookup
  import oper_addr_pkg::*;
(
  // Register file contents
  input wire logic [255:0] gpr_file_in,
  // Lookup side
  gpr_lookup_if.provider lk
);
  `include "oper_addr_params.svh"

  function automatic logic [7:0] rd(input logic [255:0] f, input logic [1:0] b,
                                    input logic [2:0] r);
    rd = f[{b, r, 3'h0} +: 8];
  endfunction

  // Pair n sits at codes 2n (low) and 2n+1 (high)
  assign lk.reg_val = rd(gpr_file_in, lk.bank, lk.reg_code);
  assign lk.pair_val = {rd(gpr_file_in, lk.bank, {lk.pair_code, 1'b1}),
                        rd(gpr_file_in, lk.bank, {lk.pair_code, 1'b0})};
  assign lk.hl_val = {rd(gpr_file_in, lk.bank, {`PAIR_HL, 1'b1}),
                      rd(gpr_file_in, lk.bank, {`PAIR_HL, 1'b0})};
  assign lk.b_val = rd(gpr_file_in, lk.bank, `REG_B);
  assign lk.c_val = rd(gpr_file_in, lk.bank, `REG_C);
endmodule // gpr_lookup
`default_nettype wire

// file: src/operand_address_generator.sv
/*
  Operand address generator: turns a decoded addressing mode plus its
  fields into a register select or one 16-bit memory address with size.
  Assumes the decoder presents a request for one cycle and the register
  file is visible as a flat vector on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "oper_addr_params.svh"
module operand_address_generator
  import oper_addr_pkg::*;
#(
  parameter logic [15:0] STACK_RAM_LO = `STACK_RAM_LO_DEF,
  parameter logic [15:0] STACK_RAM_HI = `STACK_RAM_HI_DEF
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Decoded request
  input wire logic req_valid_in,
  input wire oper_addr_pkg::addr_mode_e mode_in,
  input wire oper_addr_pkg::implied_op_e implied_op_in,
  input wire logic [2:0] reg_code_in,
  input wire logic [1:0] pair_code_in,
  input wire logic word_in,
  input wire logic use_c_index_in,
  input wire logic indirect_hl_in,
  input wire logic [15:0] imm16_in,
  input wire logic [7:0] imm8_in,
  input wire logic [15:0] sp_in,
  // Bank select flags
  input wire logic bank_select_bit0_in,
  input wire logic bank_select_bit1_in,
  // General register file, flat
  input wire logic [255:0] gpr_file_in,
  // Result
  output logic valid_out,
  output logic mem_op_out,
  output logic [15:0] eff_addr_out,
  output logic word_out,
  output logic reg_op_out,
  output logic [1:0] bank_out,
  output logic [2:0] src_reg_out,
  output logic [1:0] dst_pair_out,
  output logic stack_fault_out
);
  gpr_lookup_if lk();

  logic [1:0] bank;
  logic [15:0] addr_d;
  logic mem_d;
  logic reg_d;
  logic [2:0] src_reg_d;
  logic [1:0] dst_pair_d;
  logic sfault_d;
  logic valid_q;
  logic mem_q;
  logic [15:0] addr_q;
  logic word_q;
  logic reg_q;
  logic [1:0] bank_q;
  logic [2:0] src_reg_q;
  logic [1:0] dst_pair_q;
  logic sfault_q;

  // Short direct mapping: low byte kept, bit 8 inverted range flag
  function automatic logic [15:0] saddr_map(input logic [7:0] v);
    saddr_map = {7'h7F, (v < `SADDR_SFR_SPLIT), v};
  endfunction

  function automatic logic in_stack_ram(input logic [15:0] a);
    in_stack_ram = (a >= STACK_RAM_LO) && (a <= STACK_RAM_HI);
  endfunction

  assign bank = {bank_select_bit1_in, bank_select_bit0_in};
  assign lk.bank = bank;
  assign lk.reg_code = reg_code_in;
  assign lk.pair_code = pair_code_in;

  gpr_lookup u_lookup (
    .gpr_file_in(gpr_file_in),
    .lk(lk)
  );

  always_comb
  begin
    addr_d = 16'h0000;
    mem_d = 1'b0;
    reg_d = 1'b0;
    src_reg_d = reg_code_in;
    dst_pair_d = `PAIR_AX;
    sfault_d = 1'b0;
    case (mode_in)
      mode_implied:
      begin
        reg_d = 1'b1;
        case (implied_op_in)
          imp_multiply:
            src_reg_d = `REG_A;
          imp_divide:
            src_reg_d = `REG_X;
          imp_adjust_add, imp_adjust_sub, imp_rotate_left, imp_rotate_right:
            src_reg_d = `REG_A;
          default:
            reg_d = 1'b0;
        endcase
      end
      mode_register:
      begin
        reg_d = 1'b1;
        dst_pair_d = pair_code_in;
      end
      mode_direct:
      begin
        mem_d = 1'b1;
        addr_d = imm16_in;
      end
      mode_short_direct:
      begin
        mem_d = 1'b1;
        addr_d = saddr_map(imm8_in);
      end
      mode_sfr:
      begin
        // Hole at FFD0H-FFDFH is refused rather than aliased
        addr_d = {8'hFF, imm8_in};
        mem_d = !((addr_d >= `SFR_HOLE_LO) && (addr_d <= `SFR_HOLE_HI));
      end
      mode_reg_indirect:
      begin
        mem_d = 1'b1;
        addr_d = indirect_hl_in ? lk.hl_val : lk.pair_val;
      end
      mode_based:
      begin
        mem_d = 1'b1;
        addr_d = 16'(lk.hl_val + {8'h00, imm8_in});
      end
      mode_based_indexed:
      begin
        mem_d = 1'b1;
        addr_d = 16'(lk.hl_val + {8'h00, use_c_index_in ? lk.c_val : lk.b_val});
      end
      mode_stack:
      begin
        addr_d = sp_in;
        sfault_d = !in_stack_ram(sp_in);
        mem_d = !sfault_d;
      end
      default: mem_d = 1'b0;
    endcase
  end
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      valid_q <= 1'b0;
      mem_q <= 1'b0;
      reg_q <= 1'b0;
      sfault_q <= 1'b0;
    end
    else
    begin
      valid_q <= req_valid_in;
      mem_q <= req_valid_in && mem_d;
      reg_q <= req_valid_in && reg_d;
      sfault_q <= req_valid_in && sfault_d;
    end
  end

  // Data fields reset too so outputs are defined from reset on
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      addr_q <= 16'h0000;
      word_q <= 1'b0;
      bank_q <= 2'h0;
      src_reg_q <= 3'h0;
      dst_pair_q <= 2'h0;
    end
    else if (req_valid_in)
    begin
      addr_q <= addr_d;
      word_q <= word_in || (mode_stack == mode_in);
      bank_q <= bank;
      src_reg_q <= src_reg_d;
      dst_pair_q <= dst_pair_d;
    end
  end

  assign valid_out = valid_q;
  assign mem_op_out = mem_q;
  assign eff_addr_out = addr_q;
  assign word_out = word_q;
  assign reg_op_out = reg_q;
  assign bank_out = bank_q;
  assign src_reg_out = src_reg_q;
  assign dst_pair_out = dst_pair_q;
  assign stack_fault_out = sfault_q;

  property p_saddr_window;
    @(posedge clk_in) disable iff (sys_rst_in)
    (req_valid_in && mode_in == mode_short_direct) |=>
      (eff_addr_out >= `SADDR_LO) && (eff_addr_out <= `SADDR_HI) && mem_op_out;
  endproperty
  a_saddr_window: assert property (p_saddr_window) else $error("saddr out of window");
  property p_saddr_bit8;
    @(posedge clk_in) disable iff (sys_rst_in)
    (req_valid_in && mode_in == mode_short_direct) |=>
      eff_addr_out == {7'h7F, ($past(imm8_in) < 8'h20), $past(imm8_in)};
  endproperty
  a_saddr_bit8: assert property (p_saddr_bit8) else $error("saddr bit 8 wrong");
  property p_sfr_hole;
    @(posedge clk_in) disable iff (sys_rst_in)
    (req_valid_in && mode_in == mode_sfr) |=>
      mem_op_out == !(eff_addr_out[7:4] == 4'hD) && eff_addr_out[15:8] == 8'hFF;
  endproperty
  a_sfr_hole: assert property (p_sfr_hole) else $error("sfr hole reached");
  property p_direct;
    @(posedge clk_in) disable iff (sys_rst_in)
    (req_valid_in && mode_in == mode_direct) |=> eff_addr_out == $past(imm16_in);
  endproperty
  a_direct: assert property (p_direct) else $error("direct address changed");
  property p_based;
    @(posedge clk_in) disable iff (sys_rst_in)
    (req_valid_in && mode_in == mode_based) |=>
      eff_addr_out == 16'($past(lk.hl_val) + $past(imm8_in));
  endproperty
  a_based: assert property (p_based) else $error("based sum wrong");
  property p_indexed;
    @(posedge clk_in) disable iff (sys_rst_in)
    (req_valid_in && mode_in == mode_based_indexed && !use_c_index_in) |=>
      eff_addr_out == 16'($past(lk.hl_val) + $past(lk.b_val));
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed sum wrong");
  property p_multiply;
    @(posedge clk_in) disable iff (sys_rst_in)
    (req_valid_in && mode_in == mode_implied && implied_op_in == imp_multiply) |=>
      reg_op_out && src_reg_out == 3'h1 && dst_pair_out == 2'h0 && !mem_op_out;
  endproperty
  a_multiply: assert property (p_multiply) else $error("multiply regs wrong");
  property p_divide;
    @(posedge clk_in) disable iff (sys_rst_in)
    (req_valid_in && mode_in == mode_implied && implied_op_in == imp_divide) |=>
      reg_op_out && dst_pair_out == 2'h0;
  endproperty
  a_divide: assert property (p_divide) else $error("divide pair wrong");
  property p_adjust_rotate;
    @(posedge clk_in) disable iff (sys_rst_in)
    (req_valid_in && mode_in == mode_implied &&
     implied_op_in inside {imp_adjust_add, imp_adjust_sub, imp_rotate_left, imp_rotate_right})
      |=> src_reg_out == 3'h1;
  endproperty
  a_adjust_rotate: assert property (p_adjust_rotate) else $error("A not implied");
  property p_stack;
    @(posedge clk_in) disable iff (sys_rst_in)
    (req_valid_in && mode_in == mode_stack) |=>
      eff_addr_out == $past(sp_in) && (mem_op_out != stack_fault_out);
  endproperty
  a_stack: assert property (p_stack) else $error("stack address wrong");
  property p_bank;
    @(posedge clk_in) disable iff (sys_rst_in)
    req_valid_in |=> bank_out == {$past(bank_select_bit1_in), $past(bank_select_bit0_in)};
  endproperty
  a_bank: assert property (p_bank) else $error("bank not captured");
  property p_idle;
    @(posedge clk_in) disable iff (sys_rst_in)
    !req_valid_in |=> !valid_out && !mem_op_out && !reg_op_out;
  endproperty
  a_idle: assert property (p_idle) else $error("output without request");
  // Odd register code must be the high byte of its pair
  property p_pair_map;
    @(posedge clk_in) disable iff (sys_rst_in)
    (req_valid_in && mode_in == mode_register && reg_code_in == {pair_code_in, 1'b1}) |->
      lk.pair_val[15:8] == lk.reg_val;
  endproperty
  a_pair_map: assert property (p_pair_map) else $error("pair byte mismatch");
endmodule // operand_address_generator
`default_nettype wire

// file: verif/mem_bus_model.sv
/*
  Memory and register bus side model: holds the general register file
  and counts the memory operands it is asked to serve.
  Assumes the bench loads the file only between requests.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_bus_model
(
  // Clock
  input wire logic clk_in,
  // Operand from the generator
  input wire logic valid_in,
  input wire logic mem_op_in,
  // Register file contents
  output logic [255:0] gpr_file_out
);
  int access_cnt = 0;

  always_ff @(posedge clk_in)
  begin
    if (valid_in && mem_op_in)
      access_cnt <= access_cnt + 1;
  end

  task automatic load(input logic [255:0] v);
    gpr_file_out = v;
  endtask

  initial gpr_file_out = '0;
endmodule // mem_bus_model
`default_nettype wire

// file: verif/tb_top.sv
/*
  Self-checking bench for the operand address generator.
  Assumes the design package is compiled first; inputs move on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
  begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  import oper_addr_pkg::*;
  localparam logic [15:0] LO = 16'hFB00;
  localparam logic [15:0] HI = 16'hFEFF;
  logic clk_in, sys_rst_in, req, w, uc, hl, b0, b1;
  addr_mode_e mode;
  implied_op_e iop;
  logic [2:0] rc, so;
  logic [1:0] pc, bo, dp;
  logic [15:0] i16, sp, ea;
  logic [7:0] i8;
  logic [255:0] gpr;
  logic v, mo, wo, ro, sf;
  int num_errors = 0, comparisons = 0, nexp = 0, seed = 98, k;
  addr_mode_e ml[9] = '{mode_implied, mode_register, mode_direct, mode_short_direct,
    mode_sfr, mode_reg_indirect, mode_based, mode_based_indexed, mode_stack};

  operand_address_generator #(.STACK_RAM_LO(LO), .STACK_RAM_HI(HI)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req), .mode_in(mode),
    .implied_op_in(iop), .reg_code_in(rc), .pair_code_in(pc), .word_in(w),
    .use_c_index_in(uc), .indirect_hl_in(hl), .imm16_in(i16), .imm8_in(i8),
    .sp_in(sp), .bank_select_bit0_in(b0), .bank_select_bit1_in(b1),
    .gpr_file_in(gpr), .valid_out(v), .mem_op_out(mo), .eff_addr_out(ea),
    .word_out(wo), .reg_op_out(ro), .bank_out(bo), .src_reg_out(so),
    .dst_pair_out(dp), .stack_fault_out(sf));
  mem_bus_model u_mem (.clk_in(clk_in), .valid_in(v), .mem_op_in(mo), .gpr_file_out(gpr));

  initial
  begin
    clk_in = 0;
    forever #10 clk_in = ~clk_in;
  end

  function automatic logic [7:0] rb(input logic [2:0] c);
    int i;
    i = ({30'd0, b1, b0} * 8 + {29'd0, c}) * 8;
    return gpr[i +: 8];
  endfunction

  task automatic final_report();
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One request, checked on the answer cycle and the cycle after
  task automatic go();
    logic [15:0] e, h;
    logic m, f, r, ew;
    h = {rb(3'd7), rb(3'd6)};
    e = '0;
    f = 0;
    ew = w;
    m = 1;
    r = (mode == mode_register) || (mode == mode_implied && iop != imp_none);
    case (mode)
      mode_direct: e = i16;
      mode_short_direct: e = {7'h7F, i8 < 8'h20, i8};
      mode_sfr:
      begin
        e = {8'hFF, i8};
        m = !(i8 >= 8'hD0 && i8 <= 8'hDF);
      end
      mode_reg_indirect: e = hl ? h : {rb({pc, 1'b1}), rb({pc, 1'b0})};
      mode_based: e = h + {8'h00, i8};
      mode_based_indexed: e = h + {8'h00, uc ? rb(3'd2) : rb(3'd3)};
      mode_stack:
      begin
        e = sp;
        ew = 1;
        f = (sp < LO || sp > HI);
        m = !f;
      end
      default: m = 0;
    endcase
    req = 1;
    @(negedge clk_in);
    req = 0;
    if (m)
      nexp++;
    `CHK("valid", 1'b1, v)
    `CHK("mem_op", m, mo)
    `CHK("reg_op", r, ro)
    `CHK("fault", f, sf)
    if (m)
    begin
      `CHK("addr", e, ea)
      `CHK("size", ew, wo)
    end
    if (mode == mode_register)
    begin
      `CHK("bank", {b1, b0}, bo)
      `CHK("reg", rc, so)
      `CHK("pair_sel", pc, dp)
    end
    if (mode == mode_implied && iop != imp_none)
    begin
      `CHK("src", iop == imp_divide ? 3'h0 : 3'h1, so)
      `CHK("pair", 2'h0, dp)
    end
    @(negedge clk_in);
    `CHK("valid_end", 1'b0, v)
    if (m)
      `CHK("addr_hold", e, ea)
  endtask

  task automatic newfile();
    logic [255:0] t;
    for (int j = 0; j < 8; j++)
      t[j * 32 +: 32] = $random(seed);
    u_mem.load(t);
  endtask

  task automatic run_list(input addr_mode_e md, input logic [15:0] l[]);
    mode = md;
    foreach (l[j])
    begin
      i8 = l[j][7:0];
      sp = l[j];
      go();
    end
  endtask

  initial
  begin
    {req, w, uc, hl, b0, b1, rc, pc, i16, i8, sp} = '0;
    mode = mode_implied;
    iop = imp_none;
    sys_rst_in = 1;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 0;
    `CHK("rst_valid", 1'b0, v)
    `CHK("rst_addr", 16'h0000, ea)
    newfile();
    for (k = 1; k < 7; k++)
    begin
      iop = implied_op_e'(k);
      go();
    end
    mode = mode_register;
    for (k = 0; k < 8; k++)
    begin
      rc = 3'(k);
      {b1, b0} = 2'($random(seed));
      go();
    end
    run_list(mode_short_direct, '{16'h0000, 16'h001F, 16'h0020, 16'h00FF, 16'h0030});
    run_list(mode_sfr, '{16'h0000, 16'h00CF, 16'h00D0, 16'h00DF, 16'h00E0, 16'h00FF});
    run_list(mode_stack, '{LO, HI, 16'hFAFF, 16'hFF00});
    // All ones: HL = FFFF so the sums must wrap
    u_mem.load({256{1'b1}});
    run_list(mode_based, '{16'h0010});
    mode = mode_based_indexed;
    go();
    for (k = 0; k < 300; k++)
    begin
      if (k % 20 == 0)
        newfile();
      mode = ml[$unsigned($random(seed)) % 9];
      {w, uc, hl, b0, b1, rc, pc} = 10'($random(seed));
      iop = implied_op_e'($unsigned($random(seed)) % 7);
      i16 = 16'($random(seed));
      i8 = 8'($random(seed));
      if (w)
        i8[0] = 1'b0;
      pc = hl ? pc : 2'h2;
      sp = LO + 16'($unsigned($random(seed)) % (HI - LO + 1));
      go();
    end
    `CHK("accesses", nexp, u_mem.access_cnt)
    final_report();
  end

  initial
  begin
    #200000;
    num_errors++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
